//--- verilog/serial_port_control_status.sv
/*
  Serial port control and status: APB register slave, transmit
  sequencing (preamble, break, data), receive flag handling and
  the three interrupt request levels.
  Assumes an APB master on clk and a remote station on the pins.
*/
`timescale 1ns/1ps
// How it works
// R1 - Transmit request from empty or complete flags
// R2 - Receive request from full or idle flags
// R3 - Enabling transmitter sends all-ones preamble
// R4 - Disabling transmitter finishes current character
// R5 - Re-enable during send queues idle character
// R6 - Enables not written while module disabled
// R7 - Receiver enable gates reception, keeps flags
// R8 - Standby suppresses receive requests until wake condition
// R9 - Break characters back to back, then one
// R10 - Break toggle before preamble goes ahead of it
// R11 - Received ninth bit captured with data
// R12 - Transmit ninth bit loaded with data
// R13 - Error request from enabled error flags
// R14 - Empty flag: set on load, cleared sequence
// R15 - Complete flag while nothing is shifting
// R16 - Full flag: set on receive, read sequence
// R17 - Idle flag needs a valid character first
// R18 - Overrun drops new character, guarded clear
// R19 - Noise flag on disagreeing bit samples
// R20 - Framing flag on zero stop bit
// R21 - Parity flag on failed parity check
// R22 - Module disable forces empty and complete
// R23 - Three separate level request outputs
module serial_port_control_status
  import serial_port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd_pin,
  output logic             txd_pin,
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             err_irq
);
  logic        rst_meta_ff;
  logic        rst_n;
  logic        rxd_meta_ff;
  logic        rxd_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [7:0]  ctl1_ff;
  logic [7:0]  ctl2_ff;
  logic [3:0]  err_en_ff;
  logic        tx_ninth_ff;
  logic        rx_ninth_ff;
  logic [7:0]  rx_data_ff;
  logic [7:0]  tx_buf_ff;
  logic [15:0] baud_ff;
  logic [15:0] baud_cnt_ff;
  logic        tick_ff;
  logic        tx_empty_ff;
  logic        tc_ff;
  logic        tx_arm_ff;
  logic [5:0]  rxf_ff;
  logic [5:0]  arm_ff;
  logic        idle_armed_ff;
  logic        te_prev_ff;
  logic        re_prev_ff;
  logic        pend_pre_ff;
  logic        tail_ff;
  logic        tx_irq_ff;
  logic        rx_irq_ff;
  logic        err_irq_ff;
  logic [2:0]  sel;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        me;
  logic        te;
  logic        re;
  logic        send_break;
  logic        standby;
  logic        nine;
  logic [3:0]  frame_len;
  logic [7:0]  status_v;
  logic [7:0]  ctl3_v;
  logic [7:0]  rd_v;
  logic        load_go;
  logic        load_data;
  logic        load_pre;
  logic [10:0] frame;
  logic [3:0]  load_len;
  logic        tx_busy;
  logic        rx_done;
  logic [8:0]  rx_word;
  logic        rx_noise;
  logic        rx_ferr;
  logic        rx_idle;
  logic        rx_msb;
  logic        rx_perr;
  logic        wake_by_mark;
  logic        wake_by_idle;
  logic        take_char;
  logic        store;
  logic [5:0]  rx_set;
  logic [5:0]  rx_clr;
  logic        data_rd;
  logic        data_wr;
  logic        nxt_tx_empty;
  logic [7:0]  par_src;

  function automatic logic [2:0] reg_select(input logic [7:0] a);
    unique case (a)
      ADDR_CONTROL_ONE:   reg_select = SEL_CONTROL_ONE;
      ADDR_CONTROL_TWO:   reg_select = SEL_CONTROL_TWO;
      ADDR_CONTROL_THREE: reg_select = SEL_CONTROL_THREE;
      ADDR_STATUS_ONE:    reg_select = SEL_STATUS_ONE;
      ADDR_DATA:          reg_select = SEL_DATA;
      ADDR_BAUD:          reg_select = SEL_BAUD;
      default:            reg_select = SEL_NONE;
    endcase
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_meta_ff <= 1'b1;
      rxd_ff      <= 1'b1;
    end else begin
      rxd_meta_ff <= rxd_pin;
      rxd_ff      <= rxd_meta_ff;
    end
  end

  assign sel       = reg_select(paddr);
  assign acc       = psel & penable & pready_ff;
  assign wr        = acc & pwrite;
  assign rd        = acc & ~pwrite;
  assign data_rd   = rd & (sel == SEL_DATA);
  assign data_wr   = wr & (sel == SEL_DATA);
  assign me        = ctl1_ff[C1_MODULE_ENABLE];
  assign nine      = ctl1_ff[C1_NINE_BIT];
  assign te        = ctl2_ff[C2_TX_ENABLE];
  assign re        = ctl2_ff[C2_RX_ENABLE];
  assign send_break       = ctl2_ff[C2_SEND_BREAK];
  assign standby   = ctl2_ff[C2_STANDBY];
  assign frame_len = nine ? FRAME_LEN_NINE : FRAME_LEN_EIGHT;
  assign status_v  = {tx_empty_ff, tc_ff, rxf_ff};
  assign ctl3_v    = {rx_ninth_ff, tx_ninth_ff, 2'b00, err_en_ff};

  always_comb begin
    unique case (sel)
      SEL_CONTROL_ONE:   rd_v = ctl1_ff;
      SEL_CONTROL_TWO:   rd_v = ctl2_ff;
      SEL_CONTROL_THREE: rd_v = ctl3_v;
      SEL_STATUS_ONE:    rd_v = status_v;
      SEL_DATA:          rd_v = rx_data_ff;
      default:           rd_v = 8'h00;
    endcase
  end

  // Zero wait states: answer in the first access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel & ~penable;
      pslverr_ff <= psel & ~penable & (sel == SEL_NONE);
      if (psel && !penable) begin
        prdata_ff <= (sel == SEL_BAUD) ? {16'h0000, baud_ff}
                                       : {24'h00_0000, rd_v};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_ff   <= CONTROL_RESET;
      err_en_ff <= CONTROL_RESET[3:0];
      baud_ff   <= BAUD_RESET;
    end else if (wr) begin
      if (sel == SEL_CONTROL_ONE) ctl1_ff <= pwdata[7:0] & C1_WRITE_MASK;
      // R13 error enables
      if (sel == SEL_CONTROL_THREE) begin
        err_en_ff <= pwdata[3:0] & C3_ERR_EN_MASK[3:0];
      end
      if (sel == SEL_BAUD) baud_ff <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl2_ff <= CONTROL_RESET;
    end else if (wr && sel == SEL_CONTROL_TWO) begin
      ctl2_ff <= pwdata[7:0];
      // R6 enables held
      if (!me) begin
        ctl2_ff[C2_TX_ENABLE] <= te;
        ctl2_ff[C2_RX_ENABLE] <= re;
      end
    end else if (wake_by_mark || wake_by_idle) begin
      // R8 wake clears standby
      ctl2_ff[C2_STANDBY] <= 1'b0;
    end
  end

  // Data, not control: these hold their contents through reset
  always_ff @(posedge clk) begin
    if (wr && sel == SEL_CONTROL_THREE) tx_ninth_ff <= pwdata[C3_TX_NINTH];
    if (data_wr) tx_buf_ff <= pwdata[7:0];
    // R11 ninth bit with data
    if (store) begin
      rx_data_ff  <= rx_word[7:0];
      rx_ninth_ff <= nine ? rx_word[8] : rx_word[7];
    end
  end

  // Divider period is baud_ff + 1 clocks per oversample tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt_ff <= 16'h0000;
      tick_ff     <= 1'b0;
    end else if (!me) begin
      baud_cnt_ff <= 16'h0000;
      tick_ff     <= 1'b0;
    end else begin
      tick_ff     <= (baud_cnt_ff == 16'h0000);
      baud_cnt_ff <= (baud_cnt_ff == 16'h0000) ? baud_ff
                                               : baud_cnt_ff - 16'h0001;
    end
  end

  // R4 nothing new once disabled
  // R10 break ahead of preamble
  assign load_go   = me & te & ~tx_busy &
                     (send_break | tail_ff | pend_pre_ff | ~tx_empty_ff);
  assign load_pre  = load_go & ~send_break & ~tail_ff & pend_pre_ff;
  assign load_data = load_go & ~send_break & ~tail_ff & ~pend_pre_ff;
  assign par_src   = nine ? tx_buf_ff : {1'b0, tx_buf_ff[6:0]};

  always_comb begin
    load_len = frame_len;
    if (send_break) begin
      // R9 break is all zeros
      frame = 11'h000;
    end else if (tail_ff) begin
      frame    = 11'h7FF;
      load_len = 4'h1;
    end else if (pend_pre_ff) begin
      // R3 preamble of ones
      frame = 11'h7FF;
    end else if (nine) begin
      // R12 ninth bit into frame
      frame = {1'b1,
               ctl1_ff[C1_PARITY_EN] ?
                 (^par_src ^ ctl1_ff[C1_PARITY_ODD]) : tx_ninth_ff,
               tx_buf_ff, 1'b0};
    end else if (ctl1_ff[C1_PARITY_EN]) begin
      frame = {2'b11, ^par_src ^ ctl1_ff[C1_PARITY_ODD],
               tx_buf_ff[6:0], 1'b0};
    end else begin
      frame = {2'b11, tx_buf_ff, 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      te_prev_ff  <= 1'b0;
      pend_pre_ff <= 1'b0;
      tail_ff     <= 1'b0;
    end else begin
      te_prev_ff <= te;
      // R5 re-enable queues idle
      pend_pre_ff <= (te & ~te_prev_ff) | (pend_pre_ff & ~load_pre);
      // R9 single one after break
      if (load_go) tail_ff <= send_break;
    end
  end

  // R14 set on load, cleared by sequence
  // R22 disable forces empty
  assign nxt_tx_empty = ~me | load_data |
                        (tx_empty_ff & ~(data_wr & tx_arm_ff));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty_ff <= 1'b1;
      tc_ff       <= 1'b1;
      tx_arm_ff   <= 1'b0;
    end else begin
      tx_empty_ff <= nxt_tx_empty;
      // R15 complete when nothing queued
      // R22 disable forces complete
      tc_ff <= ~me | (nxt_tx_empty & ~tx_busy & ~load_go &
                      ~(te & (pend_pre_ff | send_break | tail_ff)));
      if (rd && sel == SEL_STATUS_ONE) begin
        tx_arm_ff <= prdata_ff[S1_TX_EMPTY];
      end else if (data_wr) begin
        tx_arm_ff <= 1'b0;
      end
    end
  end

  serial_tx u_tx (
    .clk       (clk),
    .rst_n     (rst_n),
    .tick      (tick_ff),
    .load      (load_go),
    .frame     (frame),
    .frame_len (load_len),
    .txd       (txd_pin),
    .busy      (tx_busy)
  );

  serial_rx u_rx (
    .clk       (clk),
    .rst_n     (rst_n),
    .tick      (tick_ff),
    .enable    (me & re),
    .rxd       (rxd_ff),
    .nine      (nine),
    .frame_len (frame_len),
    .done      (rx_done),
    .rdata     (rx_word),
    .noise     (rx_noise),
    .ferr      (rx_ferr),
    .idle      (rx_idle)
  );

  assign rx_msb       = nine ? rx_word[8] : rx_word[7];
  // R8 standby exit conditions
  assign wake_by_mark = standby & ctl1_ff[C1_WAKE_ADDRESS] &
                        rx_done & rx_msb;
  assign wake_by_idle = standby & ~ctl1_ff[C1_WAKE_ADDRESS] & rx_idle;
  assign take_char    = rx_done & (~standby | wake_by_mark);
  // R18 new character dropped
  assign store        = take_char & ~rxf_ff[S1_RX_FULL];
  // R21 parity check
  assign rx_perr      = ctl1_ff[C1_PARITY_EN] &
                        ((nine ? ^rx_word : ^rx_word[7:0]) ^
                         ctl1_ff[C1_PARITY_ODD]);

  // R16 full on store
  // R17 idle only when armed
  // R18 overrun on full
  // R19 noise with character
  // R20 framing with character
  assign rx_set = {store,
                   rx_idle & idle_armed_ff & ~standby,
                   take_char & rxf_ff[S1_RX_FULL],
                   store & rx_noise,
                   store & rx_ferr,
                   store & rx_perr};
  assign rx_clr = arm_ff & {6{data_rd}};

  // R7 flags untouched by enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxf_ff        <= RX_FLAGS_RESET;
      arm_ff        <= RX_FLAGS_RESET;
      idle_armed_ff <= 1'b0;
      re_prev_ff    <= 1'b0;
    end else begin
      // A new event wins over a clear in the same cycle
      rxf_ff     <= rx_set | (rxf_ff & ~rx_clr);
      re_prev_ff <= re;
      // R18 clear armed only if seen set; noise armed by any status read
      if (rd && sel == SEL_STATUS_ONE) begin
        arm_ff <= {prdata_ff[5:3], 1'b1, prdata_ff[1:0]};
      end else if (data_rd) begin
        arm_ff <= RX_FLAGS_RESET;
      end
      // R17 disarm on clear or enable, rearm on store
      idle_armed_ff <= store | (idle_armed_ff &
                       ~(rx_clr[S1_IDLE] & rxf_ff[S1_IDLE]) &
                       ~(re & ~re_prev_ff));
    end
  end

  // R23 three level requests
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_irq_ff  <= 1'b0;
      rx_irq_ff  <= 1'b0;
      err_irq_ff <= 1'b0;
    end else begin
      // R1 transmit request
      // R22 blocked when disabled
      tx_irq_ff  <= me & ((tx_empty_ff & ctl2_ff[C2_TX_EMPTY_IE]) |
                          (tc_ff & ctl2_ff[C2_TX_COMPLETE_IE]));
      // R2 receive request
      // R8 suppressed in standby
      rx_irq_ff  <= ~standby &
                    ((rxf_ff[S1_RX_FULL] & ctl2_ff[C2_RX_FULL_IE]) |
                     (rxf_ff[S1_IDLE] & ctl2_ff[C2_IDLE_IE]));
      // R13 error request
      err_irq_ff <= |(rxf_ff[3:0] & err_en_ff);
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign tx_irq  = tx_irq_ff;
  assign rx_irq  = rx_irq_ff;
  assign err_irq = err_irq_ff;
endmodule

//--- shared/serial_port_pkg.sv
/*
  Shared constants of the serial port: register map, field
  positions, reset values, bit timing and receiver states.
  Assumes a 32-bit APB bus with byte addresses.
*/
package serial_port_pkg;
  localparam logic [7:0]  ADDR_CONTROL_ONE   = 8'h00;
  localparam logic [7:0]  ADDR_CONTROL_TWO   = 8'h04;
  localparam logic [7:0]  ADDR_CONTROL_THREE = 8'h08;
  localparam logic [7:0]  ADDR_STATUS_ONE    = 8'h0C;
  localparam logic [7:0]  ADDR_DATA          = 8'h10;
  localparam logic [7:0]  ADDR_BAUD          = 8'h14;

  localparam logic [2:0]  SEL_CONTROL_ONE    = 3'h0;
  localparam logic [2:0]  SEL_CONTROL_TWO    = 3'h1;
  localparam logic [2:0]  SEL_CONTROL_THREE  = 3'h2;
  localparam logic [2:0]  SEL_STATUS_ONE     = 3'h3;
  localparam logic [2:0]  SEL_DATA           = 3'h4;
  localparam logic [2:0]  SEL_BAUD           = 3'h5;
  localparam logic [2:0]  SEL_NONE           = 3'h7;

  localparam int          C1_MODULE_ENABLE   = 6;
  localparam int          C1_NINE_BIT        = 4;
  localparam int          C1_WAKE_ADDRESS    = 3;
  localparam int          C1_PARITY_EN       = 1;
  localparam int          C1_PARITY_ODD      = 0;
  localparam logic [7:0]  C1_WRITE_MASK      = 8'h5B;

  localparam int          C2_TX_EMPTY_IE     = 7;
  localparam int          C2_TX_COMPLETE_IE  = 6;
  localparam int          C2_RX_FULL_IE      = 5;
  localparam int          C2_IDLE_IE         = 4;
  localparam int          C2_TX_ENABLE       = 3;
  localparam int          C2_RX_ENABLE       = 2;
  localparam int          C2_STANDBY         = 1;
  localparam int          C2_SEND_BREAK      = 0;

  localparam int          C3_RX_NINTH        = 7;
  localparam int          C3_TX_NINTH        = 6;
  localparam logic [7:0]  C3_ERR_EN_MASK     = 8'h0F;

  localparam int          S1_TX_EMPTY        = 7;
  localparam int          S1_TX_COMPLETE     = 6;
  localparam int          S1_RX_FULL         = 5;
  localparam int          S1_IDLE            = 4;

  localparam logic [7:0]  CONTROL_RESET      = 8'h00;
  localparam logic [15:0] BAUD_RESET         = 16'h0020;
  localparam logic [5:0]  RX_FLAGS_RESET     = 6'h00;

  localparam logic [3:0]  OVERSAMPLE_LAST    = 4'hF;
  localparam logic [3:0]  SAMPLE_FIRST       = 4'h7;
  localparam logic [3:0]  SAMPLE_LAST        = 4'h9;
  localparam logic [3:0]  FRAME_LEN_EIGHT    = 4'hA;
  localparam logic [3:0]  FRAME_LEN_NINE     = 4'hB;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_type;
endpackage

//--- verilog/serial_tx.sv
/*
  Transmit shifter: sends a frame of up to 11 bits, LSB first,
  one bit per 16 oversample ticks, line high when idle.
  Assumes load only while busy is low.
*/
`timescale 1ns/1ps
module serial_tx
  import serial_port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        load,
  input  wire logic [10:0] frame,
  input  wire logic [3:0]  frame_len,
  output logic             txd,
  output logic             busy
);
  logic [10:0] shift_ff;
  logic [3:0]  left_ff;
  logic [3:0]  sub_ff;
  logic        txd_ff;

  assign txd  = txd_ff;
  assign busy = (left_ff != 4'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= 11'h000;
      left_ff  <= 4'h0;
      sub_ff   <= 4'h0;
      txd_ff   <= 1'b1;
    end else if (load) begin
      txd_ff   <= frame[0];
      shift_ff <= {1'b1, frame[10:1]};
      left_ff  <= frame_len;
      sub_ff   <= 4'h0;
    end else if (busy && tick) begin
      sub_ff <= sub_ff + 4'h1;
      if (sub_ff == OVERSAMPLE_LAST) begin
        left_ff  <= left_ff - 4'h1;
        // Last bit held, so breaks join with no gap
        if (left_ff != 4'h1) txd_ff <= shift_ff[0];
        shift_ff <= {1'b1, shift_ff[10:1]};
      end
    end else if (!busy) begin
      txd_ff <= 1'b1;
    end
  end
endmodule

//--- verilog/serial_rx.sv
/*
  Receive shifter: 16x oversampling, majority of three samples
  per bit, noise when the samples differ, idle after a full
  frame of ones. Assumes rxd is already synchronised.
*/
`timescale 1ns/1ps
module serial_rx
  import serial_port_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic       rxd,
  input  wire logic       nine,
  input  wire logic [3:0] frame_len,
  output logic            done,
  output logic [8:0]      rdata,
  output logic            noise,
  output logic            ferr,
  output logic            idle
);
  rx_state_type state_ff;
  logic [3:0]   sub_ff;
  logic [2:0]   smp_ff;
  logic [3:0]   bit_ff;
  logic [8:0]   data_ff;
  logic         noise_ff;
  logic         noise_out_ff;
  logic         done_ff;
  logic         ferr_ff;
  logic         idle_ff;
  logic [7:0]   idle_cnt_ff;
  logic         bit_end;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic noisy(input logic [2:0] s);
    noisy = (|s) & ~(&s);
  endfunction

  assign done    = done_ff;
  assign rdata   = data_ff;
  assign noise   = noise_out_ff;
  assign ferr    = ferr_ff;
  assign idle    = idle_ff;
  assign bit_end = tick && (sub_ff == OVERSAMPLE_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_ff <= 4'h0;
      smp_ff <= 3'h0;
    end else if (!enable || state_ff == RX_IDLE) begin
      sub_ff <= (tick && !rxd) ? 4'h1 : 4'h0;
    end else if (tick) begin
      sub_ff <= sub_ff + 4'h1;
      if (sub_ff >= SAMPLE_FIRST && sub_ff <= SAMPLE_LAST) begin
        smp_ff <= {smp_ff[1:0], rxd};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= RX_IDLE;
      bit_ff       <= 4'h0;
      data_ff      <= 9'h000;
      noise_ff     <= 1'b0;
      noise_out_ff <= 1'b0;
      done_ff      <= 1'b0;
      ferr_ff      <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!enable) begin
        state_ff <= RX_IDLE;
      end else begin
        unique case (state_ff)
          RX_IDLE: if (tick && !rxd) begin
            state_ff <= RX_START;
            noise_ff <= 1'b0;
          end
          RX_START: if (bit_end) begin
            // A high majority is a false start
            state_ff <= maj3(smp_ff) ? RX_IDLE : RX_DATA;
            noise_ff <= noisy(smp_ff);
            bit_ff   <= 4'h0;
          end
          RX_DATA: if (bit_end) begin
            data_ff[bit_ff] <= maj3(smp_ff);
            noise_ff        <= noise_ff | noisy(smp_ff);
            bit_ff          <= bit_ff + 4'h1;
            if (bit_ff == (nine ? 4'h8 : 4'h7)) begin
              state_ff <= RX_STOP;
            end
          end
          RX_STOP: if (bit_end) begin
            state_ff     <= RX_IDLE;
            done_ff      <= 1'b1;
            ferr_ff      <= ~maj3(smp_ff);
            noise_out_ff <= noise_ff | noisy(smp_ff);
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_ff <= 8'h00;
      idle_ff     <= 1'b0;
    end else begin
      idle_ff <= 1'b0;
      if (!enable || !rxd || state_ff != RX_IDLE) begin
        idle_cnt_ff <= 8'h00;
      end else if (tick && idle_cnt_ff != 8'hFF) begin
        idle_cnt_ff <= idle_cnt_ff + 8'h01;
        idle_ff     <= (idle_cnt_ff == {frame_len, 4'h0} - 8'h01);
      end
    end
  end
endmodule

//--- bench/serial_port_monitor.sv
/* Checker of the serial port pins and APB slave.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ps
module serial_port_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd_pin,
  input wire logic        txd_pin,
  input wire logic        tx_irq,
  input wire logic        rx_irq,
  input wire logic        err_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready off access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error w/o ready");
  property p_map; psel && !penable && paddr > 8'h14 |=> pslverr;
  endproperty
  a_map: assert property (p_map) else $error("unmapped accepted");
  property p_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("unmapped data");
  property p_up; pready && !pwrite |-> prdata[31:16] == 16'h0;
  endproperty
  a_up: assert property (p_up) else $error("upper bits set");
  property p_bit; $fell(txd_pin) |-> !txd_pin [*8]; endproperty
  a_bit: assert property (p_bit)
    else $error("low bit too short");
  c_tx: cover property ($rose(tx_irq));
  c_rx: cover property ($rose(rx_irq));
  c_err: cover property ($rose(err_irq));
endmodule

//--- bench/serial_station.sv
/* Remote serial station: 8-bit frames, 16 clocks a bit.
   Assumes baud divisor 0 in the device. */
`timescale 1ns/1ps
module serial_station (
  input wire logic clk,
  input wire logic txd,
  output logic     rxd
);
  logic [7:0] got;
  int         count;
  initial begin
    rxd = 1'b1;
    count = 0;
  end
  // Stop given so a framing fault can be commanded
  task send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // Mid-bit sampling, LSB first
  always begin
    @(negedge txd);
    repeat (8) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      repeat (16) @(posedge clk);
      got[k] = txd;
    end
    count++;
  end
endmodule

//--- bench/serial_port_control_status_tb.sv
/* Testbench of the serial port: APB master and checks.
   Assumes the station model and the bound monitor. */
`timescale 1ns/1ps
module serial_port_control_status_tb;
  import serial_port_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        rxd_pin, txd_pin, tx_irq, rx_irq, err_irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          err_total, compares;
  initial clk = 1'b0;
  always #10 clk = ~clk;
  serial_port_control_status uut (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
  serial_station stn (.clk(clk), .txd(txd_pin), .rxd(rxd_pin));
  task close_out;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      close_out;
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task hold(input logic v, input int c);
    logic ok;
    ok = 1'b1;
    repeat (c) begin
      @(negedge clk);
      if (txd_pin !== v) ok = 1'b0;
    end
    chk({31'h0, ok}, 32'h1);
  endtask
  task t_reset;
    rdc(ADDR_STATUS_ONE, 32'hC0);
    rdc(ADDR_CONTROL_TWO, 32'h00);
    apb(1'b1, ADDR_CONTROL_TWO, 32'h0C);
    rdc(ADDR_CONTROL_TWO, 32'h00);
    apb(1'b0, ADDR_CONTROL_THREE, 32'h0);
    chk(q & 32'h0F, 32'h0);
    rdc(8'h18, 32'h0);
    $display("t_reset done");
  endtask
  task t_tx;
    apb(1'b1, ADDR_BAUD, 32'h0);
    apb(1'b1, ADDR_CONTROL_ONE, 32'h40);
    apb(1'b1, ADDR_CONTROL_TWO, 32'h08);
    hold(1'b1, 150);
    repeat (30) @(posedge clk);
    rdc(ADDR_STATUS_ONE, 32'hC0);
    apb(1'b1, ADDR_DATA, 32'hA5);
    repeat (165) @(posedge clk);
    hold(1'b1, 200);
    chk({24'h0, stn.got}, 32'hA5);
    apb(1'b1, ADDR_CONTROL_TWO, 32'h48);
    repeat (2) @(negedge clk);
    chk({31'h0, tx_irq}, 32'h1);
    apb(1'b1, ADDR_CONTROL_ONE, 32'h00);
    repeat (2) @(negedge clk);
    chk({31'h0, tx_irq}, 32'h0);
    apb(1'b1, ADDR_CONTROL_ONE, 32'h40);
    apb(1'b1, ADDR_CONTROL_TWO, 32'h08);
    apb(1'b0, ADDR_STATUS_ONE, 32'h0);
    apb(1'b1, ADDR_DATA, 32'h0F);
    repeat (40) @(posedge clk);
    apb(1'b1, ADDR_CONTROL_TWO, 32'h00);
    repeat (125) @(posedge clk);
    hold(1'b1, 200);
    chk({24'h0, stn.got}, 32'h0F);
    $display("t_tx done");
  endtask
  task t_rx;
    apb(1'b1, ADDR_CONTROL_TWO, 32'h24);
    stn.send(8'h3C, 1'b1);
    chk({31'h0, rx_irq}, 32'h1);
    rdc(ADDR_STATUS_ONE, 32'hE0);
    rdc(ADDR_DATA, 32'h3C);
    rdc(ADDR_STATUS_ONE, 32'hC0);
    repeat (200) @(posedge clk);
    rdc(ADDR_STATUS_ONE, 32'hD0);
    rdc(ADDR_DATA, 32'h3C);
    repeat (200) @(posedge clk);
    rdc(ADDR_STATUS_ONE, 32'hC0);
    $display("t_rx done");
  endtask
  task t_err;
    apb(1'b1, ADDR_CONTROL_THREE, 32'h0A);
    stn.send(8'h11, 1'b1);
    stn.send(8'h22, 1'b1);
    chk({31'h0, err_irq}, 32'h1);
    rdc(ADDR_STATUS_ONE, 32'hE8);
    rdc(ADDR_DATA, 32'h11);
    rdc(ADDR_STATUS_ONE, 32'hC0);
    stn.send(8'h55, 1'b0);
    rdc(ADDR_STATUS_ONE, 32'hE2);
    chk({31'h0, err_irq}, 32'h1);
    rdc(ADDR_DATA, 32'h55);
    rdc(ADDR_STATUS_ONE, 32'hC0);
    apb(1'b1, ADDR_CONTROL_TWO, 32'h2D);
    repeat (40) @(posedge clk);
    hold(1'b0, 300);
    $display("t_err done");
  endtask
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    err_total = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_tx;
    t_rx;
    t_err;
    close_out;
  end
endmodule
bind serial_port_control_status serial_port_monitor mon (.clk(clk),
  .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
  .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
